/* File: pkg/rsigx_pkg.sv */
// Constants, encodings and indirect layout of the receive signaling extractor.
// Assumes one 125 MHz clock shared with the framer that feeds the block.
package rsigx_pkg;

  // ==========================================================================
  // Frame and channel geometry
  localparam int        RSIGX_NUM_CH   = 24;
  localparam int        RSIGX_CW_W     = 4;
  localparam logic [2:0] RSIGX_SIG_BIT = 3'h7;  // LSB of the channel slot
  localparam logic [2:0] RSIGX_NIB_LO  = 3'h4;  // First bit of lower nibble
  localparam logic [2:0] RSIGX_F6_LAST = 3'h5;  // Frame count modulo six
  localparam logic [2:0] RSIGX_F6_FIRST = 3'h1;
  localparam logic [3:0] RSIGX_SIDX_RST = 4'h0;
  localparam logic [1:0] RSIGX_SF_DONE  = 2'h1;  // B frame closes SF word
  localparam logic [1:0] RSIGX_ESF_DONE = 2'h3;  // Frame 24 closes ESF word

  // ==========================================================================
  // Frame formats
  typedef enum logic [1:0] {
    RSIGX_FMT_SF    = 2'b00,
    RSIGX_FMT_ESF   = 2'b01,
    RSIGX_FMT_SLC96 = 2'b10,
    RSIGX_FMT_DM    = 2'b11
  } rsigx_fmt_t;

  // ==========================================================================
  // Indirect access
  localparam int         RSIGX_IND_AW    = 7;
  localparam int         RSIGX_IND_DW    = 8;
  localparam logic [6:0] RSIGX_IND_BASE  = 7'h01;
  localparam logic [6:0] RSIGX_IND_LAST  = 7'h18;
  localparam int         RSIGX_EXT_BIT   = 4;
  localparam logic [1:0] RSIGX_BUSY_CYC  = 2'h2;
  localparam logic [7:0] RSIGX_RD_UNMAP  = 8'h00;

  // ==========================================================================
  // Output buffer
  localparam int RSIGX_FIFO_W     = 4;
  localparam int RSIGX_FIFO_DEPTH = 8;

endpackage

/* File: hdl/rsigx_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rsigx_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } rsigx_fifo_state_t;

  rsigx_fifo_state_t st_reg;
  rsigx_fifo_state_t st_next;
  logic              full;
  logic              empty;

  // ==========================================================================
  // Pointers carry one extra wrap bit so full and empty are exact
  assign empty = (st_reg.wr == st_reg.rd);
  assign full  = (st_reg.wr[AW] != st_reg.rd[AW]) &&
                 (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = st_reg.mem[st_reg.rd[AW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (in_valid_in && !full) begin
      st_next.mem[st_reg.wr[AW-1:0]] = in_data_in;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (out_ready_in && !empty) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/rsigx_top.sv */
// Receive robbed-bit signaling extractor for framed T1/J1 data.
// Assumes the framer runs on mclk_in and marks each bit with a valid strobe,
// the F bit of every frame and the F bit of each multiframe's first frame.
//
// Summary of operation
// RQ1: Signaling is taken from bit 8 of every channel in each sixth frame.
// RQ2: The stored codeword leaves in the channel's lower nibble, beside data.
// RQ3: A channel with extract enable at one copies its bits into A, B, C, D.
// RQ4: In SF the stored C and D repeat the received A and B.
// RQ5: The signaling pin is driven from the stored bits, never from the line.
// RQ6: Nothing is extracted in T1-DM format.
// RQ7: With the glitch filter on, a channel updates after two equal words.
// RQ8: Storage freezes when frame sync is lost or the elastic store slips.
// RQ9: Storage also freezes while the freeze control is one.
// RQ10: While frozen each channel keeps its last valid codeword.
// RQ11: Four-state ESF/SLC-96 takes frames 6 and 18 as A, 12 and 24 as B.
// RQ12: ESF and SLC-96 in sixteen-state mode store A, B, C and D.
// RQ13: An extracted change of a stored codeword sets that channel's own change flag.
// RQ14: With its enable at one, the interrupt is high while any flag is set.
// RQ15: Software reaches a channel by address, direction, data and busy flag.
// RQ16: Software waits for busy to clear before a new access or a data read.
`timescale 1ns/1ps
`default_nettype none
module rsigx_top
  import rsigx_pkg::*;
#(
  parameter int NUM_CH     = RSIGX_NUM_CH,
  parameter int FIFO_DEPTH = RSIGX_FIFO_DEPTH
) (
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  // Framed stream from the framer
  input  wire logic                    rx_valid_in,
  output logic                         rx_ready_out,
  input  wire logic                    rx_data_in,
  input  wire logic                    rx_fbit_in,
  input  wire logic                    rx_mframe_in,
  input  wire logic [1:0]              format_in,
  input  wire logic                    frame_sync_in,
  input  wire logic                    slip_in,
  // Configuration
  input  wire logic                    glitch_filter_enable_in,
  input  wire logic                    freeze_in,
  input  wire logic                    sixteen_state_select_in,
  input  wire logic                    signaling_change_irq_enable_in,
  // Change flags
  input  wire logic [NUM_CH-1:0]       cos_clear_in,
  output logic [NUM_CH-1:0]            channel_state_changed_flag_out,
  output logic                         irq_out,
  // Indirect access
  input  wire logic                    ind_start_in,
  input  wire logic [RSIGX_IND_AW-1:0] ind_addr_in,
  input  wire logic                    indirect_access_direction_in,
  input  wire logic [RSIGX_IND_DW-1:0] ind_wdata_in,
  output logic [RSIGX_IND_DW-1:0]      ind_rdata_out,
  output logic                         ind_busy_out,
  // Backplane side
  output logic                         out_valid_out,
  input  wire logic                    out_ready_in,
  output logic                         receive_data_out_pin_out,
  output logic                         signaling_out_pin_out,
  output logic                         out_fbit_out,
  output logic                         out_mframe_out
);

  localparam int CW = RSIGX_CW_W;

  typedef struct packed {
    logic [NUM_CH-1:0][CW-1:0] sig;      // Stored A B C D, A in bit 3
    logic [NUM_CH-1:0]         ext_en;
    logic [NUM_CH-1:0][CW-1:0] asm_cw;   // Codeword being gathered
    logic [NUM_CH-1:0][CW-1:0] prev;     // Last complete codeword taken while enabled and not frozen
    logic [NUM_CH-1:0]         cos;
    logic [2:0]                bcnt;
    logic [4:0]                ch;
    logic [2:0]                f6;
    logic [3:0]                sidx;
    logic                      in_frame;
    logic                      slip_hold;
    logic                      busy;
    logic [1:0]                bsy_cnt;
    logic [RSIGX_IND_AW-1:0]   addr;
    logic                      dir_rd;
    logic [RSIGX_IND_DW-1:0]   wdata;
    logic [RSIGX_IND_DW-1:0]   rdata;
  } rsigx_state_t;

  rsigx_state_t            s_reg;
  rsigx_state_t            s_next;
  rsigx_fmt_t              fmt;
  logic                    fifo_in_ready;
  logic                    take;
  logic                    frozen;
  logic                    sig_bit;
  logic [RSIGX_FIFO_W-1:0] push_word;
  logic [RSIGX_FIFO_W-1:0] pop_word;

  assign fmt = rsigx_fmt_t'(format_in);

  // ==========================================================================
  // Freeze sources
  // RQ8 auto freeze
  // RQ9 forced freeze
  assign frozen = freeze_in | ~frame_sync_in | slip_in | s_reg.slip_hold;

  // ==========================================================================
  // Signaling serializer
  // RQ2 nibble alignment
  // RQ5 from storage
  always_comb begin
    sig_bit = 1'b0;
    if (s_reg.in_frame && !rx_fbit_in && s_reg.ch < NUM_CH[4:0] &&
        s_reg.bcnt >= RSIGX_NIB_LO) begin
      sig_bit = s_reg.sig[s_reg.ch][~s_reg.bcnt[1:0]];
    end
  end

  assign take      = rx_valid_in & fifo_in_ready;
  assign push_word = {rx_mframe_in, rx_fbit_in, rx_data_in, sig_bit};

  // ==========================================================================
  // Extraction, storage and indirect access
  always_comb begin
    logic [1:0]    k;
    logic [1:0]    slot;
    logic [CW-1:0] cw;
    logic          done;
    logic          two_pair;
    logic [4:0]    ich;
    k        = 2'h0;
    slot     = 2'h0;
    cw       = '0;
    done     = 1'b0;
    two_pair = 1'b0;
    ich      = 5'h0;
    s_next   = s_reg;
    s_next.cos = s_reg.cos & ~cos_clear_in;

    if (take) begin
      if (rx_fbit_in) begin
        s_next.bcnt     = 3'h0;
        s_next.ch       = 5'h0;
        s_next.in_frame = 1'b1;
        if (rx_mframe_in) begin
          s_next.f6        = RSIGX_F6_FIRST;
          s_next.sidx      = RSIGX_SIDX_RST;
          s_next.slip_hold = 1'b0;
        end else begin
          if (s_reg.f6 == 3'h0) begin
            s_next.sidx = s_reg.sidx + 4'h1;
          end
          s_next.f6 = (s_reg.f6 == RSIGX_F6_LAST) ? 3'h0 :
                      s_reg.f6 + 3'h1;
        end
      end else if (s_reg.in_frame && s_reg.ch < NUM_CH[4:0]) begin
        // RQ1 sixth frame LSB
        // RQ6 no DM extraction
        if (s_reg.bcnt == RSIGX_SIG_BIT && s_reg.f6 == 3'h0 &&
            fmt != RSIGX_FMT_DM) begin
          // RQ11 four-state map
          // RQ12 sixteen-state map
          k = (fmt == RSIGX_FMT_SF) ? {1'b0, s_reg.sidx[0]} :
                                      s_reg.sidx[1:0];
          two_pair = (fmt == RSIGX_FMT_SF) || !sixteen_state_select_in;
          slot = two_pair ? {1'b0, k[0]} : k;
          done = (fmt == RSIGX_FMT_SF) ? (k == RSIGX_SF_DONE) :
                                         (k == RSIGX_ESF_DONE);
          cw = s_reg.asm_cw[s_reg.ch];
          cw[~slot] = rx_data_in;
          // RQ4 C D repeat
          if (two_pair) begin
            cw[1:0] = cw[3:2];
          end
          s_next.asm_cw[s_reg.ch] = cw;
          // RQ3 copy when enabled
          // RQ10 hold when frozen
          if (done && s_reg.ext_en[s_reg.ch] && !frozen) begin
            s_next.prev[s_reg.ch] = cw;
            // RQ7 two equal words
            if (!glitch_filter_enable_in || cw == s_reg.prev[s_reg.ch]) begin
              s_next.sig[s_reg.ch] = cw;
              // RQ13 change flag
              if (cw != s_reg.sig[s_reg.ch]) begin
                s_next.cos[s_reg.ch] = 1'b1;
              end
            end
          end
        end
        s_next.bcnt = s_reg.bcnt + 3'h1;
        if (s_reg.bcnt == RSIGX_SIG_BIT) begin
          s_next.ch = s_reg.ch + 5'h1;
        end
      end
    end

    // A slip arriving with a multiframe start still freezes
    if (slip_in) begin
      s_next.slip_hold = 1'b1;
    end

    // RQ15 indirect access
    if (!s_reg.busy) begin
      if (ind_start_in) begin
        s_next.busy    = 1'b1;
        s_next.bsy_cnt = RSIGX_BUSY_CYC - 2'h1;
        s_next.addr    = ind_addr_in;
        s_next.dir_rd  = indirect_access_direction_in;
        s_next.wdata   = ind_wdata_in;
      end
    end else if (s_reg.bsy_cnt != 2'h0) begin
      s_next.bsy_cnt = s_reg.bsy_cnt - 2'h1;
    end else begin
      s_next.busy = 1'b0;
      ich = 5'(s_reg.addr - RSIGX_IND_BASE);
      if (s_reg.addr >= RSIGX_IND_BASE && s_reg.addr <= RSIGX_IND_LAST) begin
        if (s_reg.dir_rd) begin
          s_next.rdata = {3'h0, s_reg.ext_en[ich], s_reg.sig[ich]};
        end else begin
          // Software write lands after extraction in the same cycle
          s_next.ext_en[ich] = s_reg.wdata[RSIGX_EXT_BIT];
          s_next.sig[ich]    = s_reg.wdata[CW-1:0];
        end
      end else if (s_reg.dir_rd) begin
        s_next.rdata = RSIGX_RD_UNMAP;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Output buffer; a stalled backplane stalls the framer through rx_ready_out
  rsigx_fifo #(
    .WIDTH (RSIGX_FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_word),
    .out_valid_out (out_valid_out),
    .out_ready_in  (out_ready_in),
    .out_data_out  (pop_word)
  );

  assign rx_ready_out             = fifo_in_ready;
  assign out_mframe_out           = pop_word[3];
  assign out_fbit_out             = pop_word[2];
  assign receive_data_out_pin_out = pop_word[1];
  assign signaling_out_pin_out    = pop_word[0];

  // ==========================================================================
  // Status
  // RQ14 interrupt gate
  assign irq_out = signaling_change_irq_enable_in & (|s_reg.cos);
  assign channel_state_changed_flag_out = s_reg.cos;
  assign ind_rdata_out = s_reg.rdata;
  assign ind_busy_out  = s_reg.busy;

endmodule
`default_nettype wire

/* File: tb/rsigx_properties.sv */
// Checker for the receive signaling extractor, bound to rsigx_top.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rsigx_props #(
  parameter int NUM_CH = 24
) (
  input wire logic              mclk_in,
  input wire logic              resetn_in,
  input wire logic              frame_sync_in,
  input wire logic              freeze_in,
  input wire logic [1:0]        format_in,
  input wire logic              signaling_change_irq_enable_in,
  input wire logic [NUM_CH-1:0] cos_clear_in,
  input wire logic [NUM_CH-1:0] channel_state_changed_flag_out,
  input wire logic              irq_out,
  input wire logic              ind_start_in,
  input wire logic              ind_busy_out,
  input wire logic              out_valid_out,
  input wire logic              out_ready_in,
  input wire logic              receive_data_out_pin_out,
  input wire logic              signaling_out_pin_out,
  input wire logic              out_fbit_out
);
  logic [NUM_CH-1:0] fl;
  assign fl = channel_state_changed_flag_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================================
  // Flags and interrupt
  property p_irq;
    irq_out == (signaling_change_irq_enable_in && |fl);
  endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_sticky;
    (fl & $past(fl & ~cos_clear_in)) == $past(fl & ~cos_clear_in);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  // Two frozen cycles, so no flag from an earlier take can land
  property p_frz;
    $past(freeze_in) && $past(freeze_in, 2) |-> (fl & ~$past(fl)) == '0;
  endproperty
  a_frz: assert property (p_frz) else $error("flag while frozen");
  property p_sync;
    !frame_sync_in [*3] |-> (fl & ~$past(fl)) == '0;
  endproperty
  a_sync: assert property (p_sync) else $error("flag out of sync");
  property p_dm;
    (format_in == 2'h3) [*3] |-> (fl & ~$past(fl)) == '0;
  endproperty
  a_dm: assert property (p_dm) else $error("flag in DM");
  // ==========================================================================
  // Indirect access and output stream
  property p_busy;
    $rose(ind_busy_out) |-> ind_busy_out [*2] ##1 !ind_busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length");
  property p_start;
    ind_start_in && !ind_busy_out |-> ##[1:2] ind_busy_out;
  endproperty
  a_start: assert property (p_start) else $error("no busy");
  property p_hold;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(
      {receive_data_out_pin_out, signaling_out_pin_out, out_fbit_out});
  endproperty
  a_hold: assert property (p_hold) else $error("head moved");
endmodule
`default_nettype wire

/* File: tb/rsigx_sink.sv */
// Backplane model: takes the serialized words, may stall.
// Assumes the bench moves stall_in just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rsigx_sink (
  input  wire logic  mclk_in,
  input  wire logic  valid_in,
  input  wire logic  sig_in,
  input  wire logic  data_in,
  input  wire logic  fbit_in,
  input  wire logic  mframe_in,
  input  wire logic  stall_in,
  output logic       ready_out,
  output logic [7:0] ch1_sig_out,
  output logic [7:0] ch1_dat_out,
  output logic [7:0] frame_out
);
  logic [7:0] pos_reg = 8'hff;
  assign ready_out = !stall_in;
  // ==========================================================================
  // channel 1 slot, all eight bits
  // Data and signaling of one word are shifted together to prove alignment
  always_ff @(posedge mclk_in) begin
    if (valid_in && ready_out) begin
      pos_reg <= fbit_in ? 8'h00 : pos_reg + 8'h01;
      if (fbit_in)
        frame_out <= mframe_in ? 8'h01 : frame_out + 8'h01;
      if (!fbit_in && pos_reg < 8'h08) begin
        ch1_sig_out <= {ch1_sig_out[6:0], sig_in};
        ch1_dat_out <= {ch1_dat_out[6:0], data_in};
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_rsigx_top.sv */
// Self-checking bench for rsigx_top with a backplane model.
// Assumes the package, design, sink and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_rsigx_top;
  import rsigx_pkg::*;
  logic mclk_in = 0, resetn_in = 0, rx_valid_in = 0, rx_data_in = 0;
  logic rx_fbit_in = 0, rx_mframe_in = 0, frame_sync_in = 1, slip_in = 0;
  logic [1:0] format_in = 2'h0;
  logic glitch_filter_enable_in = 0, freeze_in = 0;
  logic sixteen_state_select_in = 0, signaling_change_irq_enable_in = 1;
  logic [23:0] cos_clear_in = 24'h0, channel_state_changed_flag_out;
  logic ind_start_in = 0, indirect_access_direction_in = 0, stall = 0;
  logic [6:0] ind_addr_in = 7'h00;
  logic [7:0] ind_wdata_in = 8'h00, ind_rdata_out, ch1_sig;
  logic [7:0] ch1_dat, frm;
  logic rx_ready_out, irq_out, ind_busy_out, out_valid_out, out_ready_in;
  logic receive_data_out_pin_out, signaling_out_pin_out, out_fbit_out;
  logic out_mframe_out;
  int n_errors = 0, comparisons = 0, cycles = 0;
  rsigx_top #(.NUM_CH(24)) u_dut (.*);
  rsigx_sink u_sink (.mclk_in(mclk_in), .valid_in(out_valid_out),
    .sig_in(signaling_out_pin_out), .data_in(receive_data_out_pin_out),
    .fbit_in(out_fbit_out), .mframe_in(out_mframe_out), .stall_in(stall),
    .ready_out(out_ready_in), .ch1_sig_out(ch1_sig),
    .ch1_dat_out(ch1_dat), .frame_out(frm));
  always #4 mclk_in = ~mclk_in;
  // ==========================================================================
  // Shared tasks
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk_in) #1;
  endtask
  // Valid stays up between bits; the caller lowers it after a burst
  task automatic put(input logic d, input logic f, input logic m);
    rx_valid_in = 1;
    rx_data_in = d;
    rx_fbit_in = f;
    rx_mframe_in = m;
    while (rx_ready_out !== 1'b1) tick();
    tick();
  endtask
  task automatic send_mf(input int nf, input logic [3:0] w);
    for (int fr = 1; fr <= nf; fr++) begin
      put(1'b0, 1'b1, fr == 1);
      for (int i = 0; i < 192; i++)
        put(i % 8 == 7 && fr % 6 == 0 ? w[4 - fr / 6] : 1'b0, 1'b0, 1'b0);
    end
    rx_valid_in = 0;
    repeat (12) tick();
  endtask
  task automatic ind(input logic rd, input logic [6:0] a,
                     input logic [7:0] wd);
    ind_start_in = 1;
    indirect_access_direction_in = rd;
    ind_addr_in = a;
    ind_wdata_in = wd;
    tick();
    ind_start_in = 0;
    tick();
    chk(ind_busy_out, 1'b1);
    while (ind_busy_out !== 1'b0) tick();
  endtask
  task automatic rd1(input logic [7:0] exp);
    ind(1'b1, 7'h01, 8'h00);
    chk(ind_rdata_out, exp);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_fifo();
    stall = 1;
    repeat (8) put(1'b0, 1'b0, 1'b0);
    chk(rx_ready_out, 1'b0);
    rx_valid_in = 0;
    stall = 0;
    repeat (10) tick();
    chk(out_valid_out, 1'b0);
  endtask
  task automatic t_regs();
    chk(channel_state_changed_flag_out, 24'h0);
    ind(1'b0, 7'h01, 8'h10);
    rd1(8'h10);
    ind(1'b1, 7'h19, 8'h00);
    chk(ind_rdata_out, 8'h00);
  endtask
  task automatic t_sf();
    send_mf(12, 4'h8);
    rd1(8'h1a);
    chk(channel_state_changed_flag_out, 24'h1);
    chk(irq_out, 1'b1);
    signaling_change_irq_enable_in = 0;
    tick();
    chk(irq_out, 1'b0);
    signaling_change_irq_enable_in = 1;
    cos_clear_in = 24'hffffff;
    tick();
    cos_clear_in = 24'h0;
    tick();
    chk(irq_out, 1'b0);
  endtask
  task automatic t_freeze();
    freeze_in = 1;
    send_mf(12, 4'h4);
    rd1(8'h1a);
    chk(ch1_sig, 8'h0a);
    chk(ch1_dat, 8'h01);
    chk(frm, 8'h0c);
    chk(channel_state_changed_flag_out, 24'h0);
    freeze_in = 0;
  endtask
  task automatic t_esf();
    format_in = 2'h1;
    sixteen_state_select_in = 1;
    send_mf(24, 4'h6);
    rd1(8'h16);
    sixteen_state_select_in = 0;
    send_mf(24, 4'ha);
    rd1(8'h1a);
  endtask
  task automatic t_deb();
    glitch_filter_enable_in = 1;
    sixteen_state_select_in = 1;
    send_mf(24, 4'h9);
    rd1(8'h1a);
    send_mf(24, 4'h9);
    rd1(8'h19);
    glitch_filter_enable_in = 0;
  endtask
  task automatic t_hold();
    cos_clear_in = 24'hffffff;
    tick();
    cos_clear_in = 24'h0;
    for (int k = 0; k < 3; k++) begin
      frame_sync_in = k != 0;
      slip_in = k == 1;
      format_in = k == 2 ? 2'h3 : 2'h1;
      send_mf(24, 4'h0);
      rd1(8'h19);
    end
    chk(channel_state_changed_flag_out, 24'h0);
    format_in = 2'h2;
    send_mf(24, 4'h0);
    rd1(8'h10);
    chk(channel_state_changed_flag_out, 24'h1);
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    #1 resetn_in = 1;
    t_fifo();
    t_regs();
    t_sf();
    t_freeze();
    t_esf();
    t_deb();
    t_hold();
    summarize();
  end
endmodule
bind rsigx_top rsigx_props #(.NUM_CH(NUM_CH)) u_props (.*);
`default_nettype wire
